// ===== rtl/gpc_regs.vh
// register offsets, reset values and pin map of the port c block
`ifndef GPC_REGS_VH
`define GPC_REGS_VH
`define GPC_OFF_PIN_DATA    12'h000
`define GPC_OFF_DIRECTION   12'h004
`define GPC_OFF_ANALOG_SELECT_LOW_LOW   12'h008
`define GPC_OFF_ANALOG_SELECT_LOW_HIGH  12'h00C
`define GPC_OFF_PERIPH_SEL  12'h010
`define GPC_OFF_LATCH       12'h014
`define GPC_RST_DIRECTION   8'hFF
`define GPC_RST_ANALOG_SELECT_LOW_LOW   8'hFF
`define GPC_RST_ANALOG_SELECT_LOW_HIGH  8'h0F
`define GPC_RST_PERIPH_SEL  8'h00
`define GPC_RST_LATCH       8'h00
`define GPC_MASK_ANALOG_SELECT_LOW_HIGH 8'h0F
`define GPC_BIT_CMP2        0
`define GPC_BIT_PWM_B       1
`define GPC_BIT_CCP         2
`define GPC_BIT_PWM_A       3
`define GPC_BIT_SLAVE_SEL   4
`define GPC_BIT_SER_OUT     5
`define GPC_PIN_FOUR        4
`define GPC_PIN_FIVE        5
`define GPC_PIN_SIX         6
`define GPC_PIN_SEVEN       7
`define GPC_RESP_OKAY       2'b00
`define GPC_RESP_SLVERR     2'b10
`endif

// ===== rtl/gpc_sync.v
// two flip-flop synchroniser for a group of pin inputs
module gpc_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ===== rtl/gpc_port.v
// eight-bit general purpose port c with axi4-lite register access
// Summary of operation
// - direction bit one makes pin high impedance, except pin five while ccp or pwm a is selected
// - direction bit zero drives latch onto pin, unless a selected peripheral owns pin four, five, six or seven
// - eight pins, each one individually bidirectional
// - data read returns pins, write stores latch
// - pin data writes without byte lane zero copy pin levels to latch
// - direction bits govern drivers even when analog
// - analog-selected pins read back as zero
// - pin five serves capture signal or pwm
// - pin six slave select, seven serial out
module gpc_port (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  pin_in,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  pin_oe_n,
  input  wire        comparator_two_output,
  input  wire        pwm_channel_b,
  input  wire        pwm_channel_a,
  input  wire        capture_compare_out,
  input  wire        capture_compare_oe,
  output reg         capture_compare_in,
  output reg         slave_select_in,
  input  wire        serial_data_out,
  output reg  [11:0] analog_channel_sel
);
`include "gpc_regs.vh"

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [7:0]  latch_r;
  reg  [7:0]  direction_r;
  reg  [7:0]  analog_select_low_low_r;
  reg  [7:0]  analog_select_low_high_r;
  reg  [7:0]  periph_sel_r;
  reg  [11:0] awaddr_r;
  reg         aw_have_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         w_have_r;
  wire [7:0]  pin_sync;
  wire [7:0]  pin_read;
  wire [7:0]  rmw_base;
  wire [7:0]  wr_byte;
  wire        wr_fire;
  wire        wr_hit;
  reg  [31:0] rd_data;
  reg         rd_hit;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  gpc_sync #(
    .WIDTH    (8)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // analog pins c0..c3 map to low select 4..7, c6..c7 to high select 0..1
  wire [7:0] pin_analog;
  assign pin_analog = {analog_select_low_high_r[1:0], 2'b00, analog_select_low_low_r[7:4]};
  assign pin_read   = pin_sync & ~pin_analog;
  assign rmw_base   = pin_read;
  assign wr_byte    = wstrb_r[0] ? wdata_r[7:0] : rmw_base;

  // ****************************************************************
  // write channel
  // ****************************************************************
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_hit  = (awaddr_r[11:2] == `GPC_OFF_PIN_DATA >> 2)
                || (awaddr_r[11:2] == `GPC_OFF_DIRECTION >> 2)
                || (awaddr_r[11:2] == `GPC_OFF_ANALOG_SELECT_LOW_LOW >> 2)
                || (awaddr_r[11:2] == `GPC_OFF_ANALOG_SELECT_LOW_HIGH >> 2)
                || (awaddr_r[11:2] == `GPC_OFF_PERIPH_SEL >> 2);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GPC_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register updates on a completed write, byte lane zero only except pin data, which loads the latch on every write
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_r      <= `GPC_RST_LATCH;
      direction_r  <= `GPC_RST_DIRECTION;
      analog_select_low_low_r  <= `GPC_RST_ANALOG_SELECT_LOW_LOW;
      analog_select_low_high_r <= `GPC_RST_ANALOG_SELECT_LOW_HIGH;
      periph_sel_r <= `GPC_RST_PERIPH_SEL;
    end else if (wr_fire) begin
      case (awaddr_r[11:2])
        `GPC_OFF_PIN_DATA >> 2: begin
          latch_r <= wr_byte;
        end
        `GPC_OFF_DIRECTION >> 2: begin
          if (wstrb_r[0]) begin
            direction_r <= wdata_r[7:0];
          end
        end
        `GPC_OFF_ANALOG_SELECT_LOW_LOW >> 2: begin
          if (wstrb_r[0]) begin
            analog_select_low_low_r <= wdata_r[7:0];
          end
        end
        `GPC_OFF_ANALOG_SELECT_LOW_HIGH >> 2: begin
          if (wstrb_r[0]) begin
            analog_select_low_high_r <= wdata_r[7:0] & `GPC_MASK_ANALOG_SELECT_LOW_HIGH;
          end
        end
        `GPC_OFF_PERIPH_SEL >> 2: begin
          if (wstrb_r[0]) begin
            periph_sel_r <= {2'b00, wdata_r[5:0]};
          end
        end
        default: begin
          latch_r <= latch_r;
        end
      endcase
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  always @* begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    case (s_axi_araddr[11:2])
      `GPC_OFF_PIN_DATA >> 2:   rd_data[7:0] = pin_read;
      `GPC_OFF_DIRECTION >> 2:  rd_data[7:0] = direction_r;
      `GPC_OFF_ANALOG_SELECT_LOW_LOW >> 2:  rd_data[7:0] = analog_select_low_low_r;
      `GPC_OFF_ANALOG_SELECT_LOW_HIGH >> 2: rd_data[7:0] = analog_select_low_high_r;
      `GPC_OFF_PERIPH_SEL >> 2: rd_data[7:0] = periph_sel_r;
      `GPC_OFF_LATCH >> 2:      rd_data[7:0] = latch_r;
      default:                  rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `GPC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // pin drivers and peripheral muxing
  // ****************************************************************
  reg [7:0] out_nxt;
  reg [7:0] oe_n_nxt;

  always @* begin
    out_nxt  = latch_r;
    oe_n_nxt = direction_r;
    if (periph_sel_r[`GPC_BIT_CMP2]) begin
      out_nxt[`GPC_PIN_FOUR] = comparator_two_output;
    end else if (periph_sel_r[`GPC_BIT_PWM_B]) begin
      out_nxt[`GPC_PIN_FOUR] = pwm_channel_b;
    end
    if (periph_sel_r[`GPC_BIT_CCP]) begin
      out_nxt[`GPC_PIN_FIVE]  = capture_compare_out;
      oe_n_nxt[`GPC_PIN_FIVE] = !capture_compare_oe;
    end else if (periph_sel_r[`GPC_BIT_PWM_A]) begin
      out_nxt[`GPC_PIN_FIVE]  = pwm_channel_a;
      oe_n_nxt[`GPC_PIN_FIVE] = 1'b0;
    end
    if (periph_sel_r[`GPC_BIT_SLAVE_SEL]) begin
      oe_n_nxt[`GPC_PIN_SIX] = 1'b1;
    end
    if (periph_sel_r[`GPC_BIT_SER_OUT]) begin
      out_nxt[`GPC_PIN_SEVEN] = serial_data_out;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out            <= `GPC_RST_LATCH;
      pin_oe_n           <= `GPC_RST_DIRECTION;
      capture_compare_in <= 1'b0;
      slave_select_in    <= 1'b1;
      analog_channel_sel <= 12'h000;
    end else begin
      pin_out            <= out_nxt;
      pin_oe_n           <= oe_n_nxt;
      capture_compare_in <= pin_sync[`GPC_PIN_FIVE];
      slave_select_in    <= periph_sel_r[`GPC_BIT_SLAVE_SEL] ?
                            pin_sync[`GPC_PIN_SIX] : 1'b1;
      analog_channel_sel <= {analog_select_low_high_r[3:0], analog_select_low_low_r};
    end
  end
endmodule

// ===== test/gpc_port_monitor.sv
// assertion checker for the port c block
module gpc_port_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_oe_after_reset: assert property ($rose(reset_n) |-> pin_oe_n == 8'hFF)
    else $error("pins driven right after reset");
  a_rdata_eight: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data wider than eight bits");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");
  a_arready_cause: assert property (s_axi_arready |-> $past(s_axi_arvalid))
    else $error("read address ready without request");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_drive: cover property ($fell(pin_oe_n[0]));
endmodule

// ===== test/gpc_pins.sv
// model of the circuitry on the eight port pins
module gpc_pins (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext_drive,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven pins read back the driver, released pins the outside level
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule

// ===== test/gpc_port_tb.sv
// self-checking bench of the port c block
`include "gpc_regs.vh"
module gpc_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, comparator_two_output, pwm_channel_b, pwm_channel_a;
  logic capture_compare_out, capture_compare_oe, capture_compare_in;
  logic slave_select_in, serial_data_out;
  logic [11:0] s_axi_awaddr, s_axi_araddr, analog_channel_sel;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [7:0]  pin_in, pin_out, pin_oe_n, ext_drive, rv;
  int          mismatches, n_tests, cyc;
  gpc_port dut (.*);
  gpc_pins u_pins (.*);
  always #20 clk = ~clk;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin @(posedge clk); while (!s_axi_awready) @(posedge clk); s_axi_awvalid <= 1'b0; end
      begin @(posedge clk); while (!s_axi_wready) @(posedge clk); s_axi_wvalid <= 1'b0; end
    join
    s_axi_bready <= 1'b1;
    @(posedge clk);
    while (!s_axi_bvalid) @(posedge clk);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge clk);
    while (!s_axi_arready) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (!s_axi_rvalid) @(posedge clk);
    rv = s_axi_rdata[7:0];
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task s_reset;
    chk("oe", pin_oe_n, 8'hFF);
    rd(`GPC_OFF_DIRECTION); chk("dir", rv, 8'hFF);
    rd(`GPC_OFF_ANALOG_SELECT_LOW_LOW); chk("asl", rv, 8'hFF);
    rd(`GPC_OFF_ANALOG_SELECT_LOW_HIGH); chk("ash", rv, 8'h0F);
    rd(12'h0FC); chk("resp", rr, 2'b10);
    chk("acs", analog_channel_sel, 12'hFFF);
    wr(`GPC_OFF_LATCH, 8'h33, 4'h1); chk("wresp", rr, 2'b10);
    rd(`GPC_OFF_LATCH); chk("lat0", rv, 8'h00);
  endtask
  task s_analog;
    rd(`GPC_OFF_PIN_DATA); chk("ana", rv, 8'h30);
    wr(`GPC_OFF_ANALOG_SELECT_LOW_LOW, 8'h00, 4'h1);
    wr(`GPC_OFF_ANALOG_SELECT_LOW_HIGH, 8'h00, 4'h1); chk("okresp", rr, 2'b00);
    repeat (4) @(posedge clk);
    rd(`GPC_OFF_PIN_DATA); chk("dig", rv, 8'hFF);
  endtask
  task s_drive;
    wr(`GPC_OFF_PIN_DATA, 8'h5A, 4'h1);
    wr(`GPC_OFF_DIRECTION, 8'h00, 4'h1);
    repeat (2) @(posedge clk);
    chk("oe", pin_oe_n, 8'h00);
    chk("out", pin_out, 8'h5A);
    ext_drive <= 8'h9C;
    wr(`GPC_OFF_DIRECTION, 8'hF0, 4'h1);
    wr(`GPC_OFF_ANALOG_SELECT_LOW_LOW, 8'hFF, 4'h1);
    repeat (4) @(posedge clk);
    chk("oe", pin_oe_n, 8'hF0);
    rd(`GPC_OFF_PIN_DATA); chk("mix", rv, 8'h90);
    wr(`GPC_OFF_ANALOG_SELECT_LOW_LOW, 8'h00, 4'h1);
    repeat (4) @(posedge clk);
    wr(`GPC_OFF_PIN_DATA, 8'h00, 4'h0);
    rd(`GPC_OFF_LATCH); chk("rmw", rv, 8'h9A);
  endtask
  task s_periph;
    // pwm b stays low while the comparator owns pin four
    capture_compare_out <= 1'b1;
    capture_compare_oe <= 1'b1;
    wr(`GPC_OFF_DIRECTION, 8'h00, 4'h1);
    wr(`GPC_OFF_PERIPH_SEL, 8'h35, 4'h1);
    repeat (4) @(posedge clk);
    chk("per", {pin_out[7], pin_out[5], pin_out[4]}, 3'b010);
    chk("ssoe", pin_oe_n[6], 1'b1);
    chk("ss", slave_select_in, 1'b0);
    chk("ccp", capture_compare_in, 1'b1);
    pwm_channel_b <= 1'b1;
    pwm_channel_a <= 1'b1;
    wr(`GPC_OFF_PERIPH_SEL, 8'h0A, 4'h1);
    repeat (4) @(posedge clk);
    chk("pwm", {pin_out[5], pin_out[4]}, 2'b11);
    chk("pwmoe", pin_oe_n[5], 1'b0);
    chk("acs0", analog_channel_sel, 12'h000);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    {clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, comparator_two_output, pwm_channel_b, pwm_channel_a} = '0;
    {capture_compare_out, capture_compare_oe, serial_data_out, cyc} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    ext_drive = 8'hFF;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    s_reset;
    s_analog;
    s_drive;
    s_periph;
    conclude;
  end
endmodule
bind gpc_port gpc_port_monitor u_mon (.clk(clk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .pin_oe_n(pin_oe_n));
